// ===== bench/eid_pin_model.sv
// Outside sources driving the request, key and non-maskable pins
`timescale 1ns/1ps
module eid_pin_model import eid_pkg::*;
(
  input  wire logic               core_clk,
  output logic      [EXT_NUM-1:0] ext_request_pin,
  output logic                    nmi_pin,
  output logic      [KEY_NUM-1:0] key_input_pins
);
  // Pins rest high as with a pull-up
  initial begin
    ext_request_pin = '1;
    nmi_pin = 1'b1;
    key_input_pins = '1;
  end
  // Each level is held long enough for the synchroniser to see it
  task automatic set_ext(input int i, input logic v);
    @(posedge core_clk);
    ext_request_pin[i] <= v;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic set_nmi(input logic v);
    @(posedge core_clk);
    nmi_pin <= v;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic set_key(input int i, input logic v);
    @(posedge core_clk);
    key_input_pins[i] <= v;
    repeat (3) @(posedge core_clk);
  endtask
endmodule // eid_pin_model

// ===== bench/eid_top_asserts.sv
// Port-level checker for the request detection block
`timescale 1ns/1ps
module eid_top_asserts import eid_pkg::*; #(
  parameter int FETCH_W = 20
) (
  input wire logic                      core_clk,
  input wire logic                      reset_n,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic                      nmi_pin,
  input wire logic                      insn_start,
  input wire logic                      ack_valid,
  input wire eid_src_type               ack_src,
  input wire logic [EXT_NUM-1:0]        ext_irq_req,
  input wire logic [EXT_NUM*PRIO_W-1:0] ext_prio_lvl,
  input wire logic                      key_irq_req,
  input wire logic [PRIO_W-1:0]         key_prio_lvl,
  input wire logic                      key_wake_req,
  input wire logic                      nmi_req,
  input wire logic                      match_req
);
  logic [2:0]         nmi_hi_cnt;
  logic [EXT_NUM-1:0] prio_on;
  logic               bus_wr;
  // Counts how long the non-maskable pin has stayed high
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) nmi_hi_cnt <= 3'h0;
    else if (!nmi_pin) nmi_hi_cnt <= 3'h0;
    else if (nmi_hi_cnt != 3'h7) nmi_hi_cnt <= nmi_hi_cnt + 3'h1;
  end
  always_comb begin
    for (int i = 0; i < EXT_NUM; i++) prio_on[i] = |ext_prio_lvl[i*PRIO_W +: PRIO_W];
  end
  assign bus_wr = psel && penable && pwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  prio_gate_a: assert property ((ext_irq_req & ~prio_on) == '0)
    else $error("request out with priority zero");
  ext_hold_a: assert property (!bus_wr && !ack_valid |=>
    ($past(ext_irq_req) & ~ext_irq_req) == '0) else $error("request dropped alone");
  key_gate_a: assert property (key_irq_req |-> key_wake_req && key_prio_lvl != 3'h0)
    else $error("key request without flag");
  key_hold_a: assert property (key_wake_req && !bus_wr && !ack_valid |=> key_wake_req)
    else $error("key flag dropped alone");
  nmi_fall_a: assert property (($fell(nmi_pin) ##1 !nmi_pin [*2]) |-> ##[0:2] nmi_req)
    else $error("falling edge missed");
  nmi_hold_a: assert property (nmi_req && !(ack_valid && ack_src == EID_SRC_NMI) |=> nmi_req)
    else $error("nmi request dropped alone");
  nmi_ack_a: assert property (ack_valid && ack_src == EID_SRC_NMI && nmi_hi_cnt >= 3'h4
    |=> !nmi_req) else $error("acknowledge did not clear");
  match_start_a: assert property (!insn_start |-> !match_req)
    else $error("match without instruction start");
  err_phase_a: assert property (pslverr |-> psel && penable && pready)
    else $error("error outside access phase");

  cover property ($rose(nmi_req));
  cover property ($rose(key_irq_req));
  cover property (match_req);
  cover property ($rose(ext_irq_req[5]));
endmodule // eid_top_asserts

// ===== bench/eid_top_tb.sv
// Self-checking bench for the request detection block
`timescale 1ns/1ps
module eid_top_tb import eid_pkg::*;;
  logic                      core_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [PADDR_W-1:0]        paddr;
  logic [31:0]               pwdata, prdata, rd;
  logic [EXT_NUM-1:0]        ext_pin, ext_irq_req;
  logic [KEY_NUM-1:0]        key_pin, key_mode;
  logic [EXT_NUM*PRIO_W-1:0] ext_prio_lvl;
  logic [PRIO_W-1:0]         key_prio_lvl;
  logic [19:0]               fetch_addr;
  logic                      nmi_pin, key_irq_req, key_wake_req, nmi_req, match_req;
  logic                      sel_a, sel_b, ack_valid, insn_start;
  eid_src_type               ack_src;
  int                        n_fail, checks_done;

  eid_top #(.FETCH_W(20), .SYNC_STAGES(2)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_request_pin(ext_pin),
    .nmi_pin(nmi_pin), .key_input_pins(key_pin), .key_pin_input_mode(key_mode),
    .fetch_addr(fetch_addr), .insn_start(insn_start), .ack_valid(ack_valid),
    .ack_src(ack_src), .ext_irq_req(ext_irq_req), .ext_prio_lvl(ext_prio_lvl),
    .key_irq_req(key_irq_req), .key_prio_lvl(key_prio_lvl), .key_wake_req(key_wake_req),
    .nmi_req(nmi_req), .match_req(match_req), .serial_src_sel_a(sel_a),
    .serial_src_sel_b(sel_b));
  eid_pin_model pins (.core_clk(core_clk), .ext_request_pin(ext_pin), .nmi_pin(nmi_pin),
    .key_input_pins(key_pin));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic ack(input eid_src_type s);
    @(posedge core_clk);
    ack_valid <= 1'b1;
    ack_src <= s;
    @(posedge core_clk);
    ack_valid <= 1'b0;
    #1;
  endtask
  task automatic fetch(input logic [19:0] a, input logic s);
    @(posedge core_clk);
    fetch_addr <= a;
    insn_start <= s;
    #1;
  endtask

  task automatic reg_case();
    rdc(12'hc7c, 32'h0);
    wr(12'hc7c, 32'hff);
    rdc(12'hc7c, 32'hff);
    chk({sel_a, sel_b}, 2'b11);
    wr(12'hc7c, 32'h40);
    tick(1);
    chk({sel_a, sel_b}, 2'b10);
    rdc(12'h120, 32'h1f);
    apb(1'b0, 12'h200, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("register test done");
  endtask
  task automatic edge_case(input int i, input logic polarity_sel, input logic both,
                           input logic [2:0] pr, input logic ef, input logic er);
    logic [11:0] ca;
    ca = 12'(12'h100 + 4 * i);
    wr(12'hc7c, {26'h0, 6'({5'h0, both} << i)});
    wr(ca, {26'h0, 1'b0, polarity_sel, 1'b0, pr});
    pins.set_ext(i, 1'b0);
    tick(5);
    chk(ext_irq_req[i], ef && pr != 3'h0);
    chk(ext_irq_req & ~(6'h1 << i), 6'h0);
    rdc(ca, {26'h0, 1'b0, polarity_sel, ef, pr});
    chk(ext_prio_lvl[i*PRIO_W +: PRIO_W], pr);
    wr(ca, {26'h0, 1'b0, polarity_sel, 1'b0, pr});
    pins.set_ext(i, 1'b1);
    tick(5);
    rdc(ca, {26'h0, 1'b0, polarity_sel, er, pr});
    wr(ca, {26'h0, 1'b0, polarity_sel, 1'b0, pr});
    $display("edge test on pin %0d done", i);
  endtask
  task automatic level_case();
    wr(12'hc7c, 32'h0);
    wr(12'h114, 32'h24);
    pins.set_ext(5, 1'b0);
    tick(5);
    chk(ext_irq_req[5], 1'b1);
    wr(12'h114, 32'h24);
    tick(1);
    chk(ext_irq_req[5], 1'b1);
    pins.set_ext(5, 1'b1);
    tick(5);
    chk(ext_irq_req[5], 1'b1);
    ack(EID_SRC_EXT5);
    chk(ext_irq_req[5], 1'b0);
    pins.set_ext(5, 1'b0);
    pins.set_ext(5, 1'b1);
    chk(ext_irq_req[5], 1'b1);
    wr(12'h114, 32'h24);
    tick(1);
    chk(ext_irq_req[5], 1'b0);
    $display("level test done");
  endtask
  task automatic nmi_case();
    pins.set_nmi(1'b0);
    tick(5);
    chk(nmi_req, 1'b1);
    rdc(12'h120, 32'h1e);
    pins.set_nmi(1'b1);
    tick(5);
    ack(EID_SRC_NMI);
    chk(nmi_req, 1'b0);
    $display("nmi test done");
  endtask
  task automatic key_case();
    wr(12'h118, 32'h2);
    pins.set_key(0, 1'b0);
    tick(5);
    chk({key_irq_req, key_wake_req}, 2'b11);
    chk(key_prio_lvl, 3'h2);
    ack(EID_SRC_KEY);
    chk(key_wake_req, 1'b0);
    pins.set_key(1, 1'b0);
    tick(5);
    chk(key_wake_req, 1'b0);
    pins.set_key(0, 1'b1);
    pins.set_key(1, 1'b1);
    wr(12'h11c, 32'h1);
    pins.set_key(2, 1'b0);
    tick(5);
    chk(key_wake_req, 1'b0);
    rdc(12'h120, 32'h1);
    pins.set_key(2, 1'b1);
    wr(12'h11c, 32'h0);
    // Pin out of input mode must not raise the key request
    @(posedge core_clk);
    key_mode <= 4'h7;
    pins.set_key(3, 1'b0);
    tick(5);
    chk(key_wake_req, 1'b0);
    pins.set_key(3, 1'b1);
    key_mode <= 4'hf;
    $display("key test done");
  endtask
  task automatic match_case();
    wr(12'h14c, 32'h12345);
    wr(12'h124, 32'h08);
    fetch(20'h12345, 1'b1);
    chk(match_req, 1'b1);
    fetch(20'h12345, 1'b0);
    chk(match_req, 1'b0);
    wr(12'h124, 32'h0);
    fetch(20'h12345, 1'b1);
    chk(match_req, 1'b0);
    fetch(20'h0, 1'b0);
    $display("match test done");
  endtask

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ack_valid = 1'b0;
    ack_src = EID_SRC_EXT0;
    key_mode = '1;
    fetch_addr = '0;
    insn_start = 1'b0;
    n_fail = 0;
    checks_done = 0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    reg_case();
    edge_case(0, 1'b1, 1'b0, 3'h3, 1'b0, 1'b1);
    edge_case(1, 1'b0, 1'b0, 3'h5, 1'b1, 1'b0);
    edge_case(2, 1'b0, 1'b1, 3'h7, 1'b1, 1'b1);
    edge_case(3, 1'b0, 1'b1, 3'h0, 1'b1, 1'b1);
    level_case();
    nmi_case();
    key_case();
    match_case();
    end_sim();
  end
endmodule // eid_top_tb

bind eid_top eid_top_asserts #(.FETCH_W(FETCH_W)) chk_i (.core_clk(core_clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .nmi_pin(nmi_pin), .insn_start(insn_start), .ack_valid(ack_valid),
  .ack_src(ack_src), .ext_irq_req(ext_irq_req), .ext_prio_lvl(ext_prio_lvl),
  .key_irq_req(key_irq_req), .key_prio_lvl(key_prio_lvl), .key_wake_req(key_wake_req),
  .nmi_req(nmi_req), .match_req(match_req));

// ===== pkg/eid_pkg.sv
// Constants and types for the external request detection block
package eid_pkg;
  localparam int EXT_NUM   = 6;
  localparam int KEY_NUM   = 4;
  localparam int MATCH_NUM = 8;
  localparam int PRIO_W    = 3;
  localparam int IDX_W     = 10;
  localparam int PADDR_W   = 12;
  localparam int SYNC_W    = EXT_NUM + 1 + KEY_NUM;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_EDGE_SRC   = 10'h31f;
  localparam logic [IDX_W-1:0] IDX_EXT_CTRL0  = 10'h040;
  localparam logic [IDX_W-1:0] IDX_KEY_CTRL   = 10'h046;
  localparam logic [IDX_W-1:0] IDX_KEY_ANALOG = 10'h047;
  localparam logic [IDX_W-1:0] IDX_PORT_IN    = 10'h048;
  localparam logic [IDX_W-1:0] IDX_MATCH_EN   = 10'h049;
  localparam logic [IDX_W-1:0] IDX_MATCH_ADR0 = 10'h050;

  // Request control register fields
  localparam int CTRL_PRIO_LSB = 0;
  localparam int CTRL_FLAG_BIT = 3;
  localparam int CTRL_POL_BIT  = 4;
  localparam int CTRL_LVS_BIT  = 5;

  // Edge source select fields
  localparam int EDGE_SEL_A_BIT = 6;
  localparam int EDGE_SEL_B_BIT = 7;
  localparam int EDGE_SRC_W     = 8;

  // Port input register fields
  localparam int PORT_NMI_BIT = 0;
  localparam int PORT_KEY_LSB = 1;

  // Reset values
  localparam logic [EDGE_SRC_W-1:0] EDGE_SRC_RST = 8'h00;
  localparam logic [PRIO_W-1:0]     PRIO_RST     = 3'h0;
  localparam logic [SYNC_W-1:0]     PIN_IDLE     = 11'h7ff;
  localparam logic [31:0]           RD_ZERO      = 32'h0000_0000;

  typedef struct packed {
    logic              lvl_sense;
    logic              polarity;
    logic [PRIO_W-1:0] prio;
  } eid_ctrl_type;

  localparam eid_ctrl_type CTRL_RST = '{lvl_sense: 1'b0, polarity: 1'b0, prio: PRIO_RST};

  typedef enum logic [2:0] {
    EID_SRC_EXT0 = 3'b000,
    EID_SRC_EXT1 = 3'b001,
    EID_SRC_EXT2 = 3'b010,
    EID_SRC_EXT3 = 3'b011,
    EID_SRC_EXT4 = 3'b100,
    EID_SRC_EXT5 = 3'b101,
    EID_SRC_KEY  = 3'b110,
    EID_SRC_NMI  = 3'b111
  } eid_src_type;
endpackage

// ===== rtl/eid_match.sv
// Instruction fetch address comparator
`timescale 1ns/1ps
module eid_match import eid_pkg::*; #(
  parameter int FETCH_W = 20
) (
  input  wire logic [MATCH_NUM-1:0][FETCH_W-1:0] match_addr,
  input  wire logic [MATCH_NUM-1:0]              match_en,
  input  wire logic [FETCH_W-1:0]                fetch_addr,
  input  wire logic                              insn_start,
  output logic                                   match_req
);
  logic [MATCH_NUM-1:0] hit;

  for (genvar i = 0; i < MATCH_NUM; i++) begin : g_cmp
    assign hit[i] = match_en[i] && (match_addr[i] == fetch_addr);
  end

  assign match_req = insn_start && (|hit);
endmodule // eid_match

// ===== rtl/eid_sync.sv
// Multi-stage pin synchroniser
`timescale 1ns/1ps
module eid_sync import eid_pkg::*; #(
  parameter int              WIDTH   = SYNC_W,
  parameter int              STAGES  = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);
  logic [STAGES-1:0][WIDTH-1:0] stage_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_reg <= {STAGES{RST_VAL}};
    end else begin
      stage_reg <= {stage_reg[STAGES-2:0], pin_in};
    end
  end

  assign pin_sync = stage_reg[STAGES-1];
endmodule // eid_sync

// ===== rtl/eid_top.sv
// External, key, non-maskable and address-match request detection
`timescale 1ns/1ps
//
// Contract
// - Six request pins, each with its own flag, edge or level sensing.
// - Level-sense 0 is edge mode; polarity and both-edge pick the edge.
// - The configured edge sets the pin's request flag.
// - In level mode the flag is held at 1 while the level is active.
// - After the level ends, acknowledge or a written 0 clears the flag.
// - A nonzero priority field enables each pin's request.
// - Edge select bits 0-5 choose one edge or both edges per pin.
// - Bits 6 and 7 choose which serial channel feeds the shared source.
// - A high-to-low change on the non-maskable pin always raises a request.
// - The port bit of the non-maskable pin reads its input level.
// - A falling edge on any key input pin in input mode sets the key flag.
// - While one key pin is low, edges on others raise nothing new.
// - A key request wakes the device from wait and stop mode.
// - Analog select disconnects key pins from port reads and edge sensing.
// - Address match is non-maskable, raised just before the instruction runs.
// - Eight match addresses, each with its own enable bit.
// - Matching happens only on an instruction's starting address.
// - Acknowledging a source clears its request flag.
module eid_top import eid_pkg::*; #(
  parameter int FETCH_W     = 20,
  parameter int SYNC_STAGES = 2
) (
  input  wire logic                         core_clk,
  input  wire logic                         reset_n,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [PADDR_W-1:0]           paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [EXT_NUM-1:0]           ext_request_pin,
  input  wire logic                         nmi_pin,
  input  wire logic [KEY_NUM-1:0]           key_input_pins,
  input  wire logic [KEY_NUM-1:0]           key_pin_input_mode,
  input  wire logic [FETCH_W-1:0]           fetch_addr,
  input  wire logic                         insn_start,
  input  wire logic                         ack_valid,
  input  wire eid_src_type                  ack_src,
  output logic      [EXT_NUM-1:0]           ext_irq_req,
  output logic      [EXT_NUM*PRIO_W-1:0]    ext_prio_lvl,
  output logic                              key_irq_req,
  output logic      [PRIO_W-1:0]            key_prio_lvl,
  output logic                              key_wake_req,
  output logic                              nmi_req,
  output logic                              match_req,
  output logic                              serial_src_sel_a,
  output logic                              serial_src_sel_b
);
  // Byte address of a register index
  function automatic logic reg_hit(input logic [PADDR_W-1:0] addr,
                                   input logic [IDX_W-1:0]   idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  logic [SYNC_W-1:0]                   pins_sync;
  logic [EXT_NUM-1:0]                  ext_sync;
  logic                                nmi_sync;
  logic [KEY_NUM-1:0]                  key_sync;
  logic [EXT_NUM-1:0]                  ext_prev_reg;
  logic                                nmi_prev_reg;
  logic                                key_comb_prev_reg;
  logic                                key_comb;
  logic [EXT_NUM-1:0]                  ext_set;
  logic [EXT_NUM-1:0]                  ext_clr;
  logic [EXT_NUM-1:0]                  ext_flag_reg;
  eid_ctrl_type                        ext_ctrl_reg [EXT_NUM];
  logic [EDGE_SRC_W-1:0]               edge_src_reg;
  logic [PRIO_W-1:0]                   key_prio_reg;
  logic                                key_flag_reg;
  logic                                key_analog_reg;
  logic                                nmi_pend_reg;
  logic [MATCH_NUM-1:0]                match_en_reg;
  logic [MATCH_NUM-1:0][FETCH_W-1:0]   match_addr_reg;
  logic                                wr_access;
  logic                                setup_phase;
  logic [31:0]                         rd_data;
  logic                                rd_mapped;
  logic [31:0]                         prdata_reg;
  logic                                err_reg;
  logic [KEY_NUM-1:0]                  key_port_lvl;
  logic                                key_fall;
  logic                                key_clr;
  logic                                nmi_clr;

  eid_sync #(
    .WIDTH   (SYNC_W),
    .STAGES  (SYNC_STAGES),
    .RST_VAL (PIN_IDLE)
  ) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin_in   ({key_input_pins, nmi_pin, ext_request_pin}),
    .pin_sync (pins_sync)
  );

  assign ext_sync = pins_sync[EXT_NUM-1:0];
  assign nmi_sync = pins_sync[EXT_NUM];
  assign key_sync = pins_sync[SYNC_W-1:EXT_NUM+1];

  assign setup_phase = psel && !penable;
  assign wr_access   = psel && penable && pwrite && rd_mapped;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && err_reg;
  assign prdata      = prdata_reg;

  // Previous synchronised levels for edge detection
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_prev_reg      <= PIN_IDLE[EXT_NUM-1:0];
      nmi_prev_reg      <= 1'b1;
      key_comb_prev_reg <= 1'b1;
    end else begin
      ext_prev_reg      <= ext_sync;
      nmi_prev_reg      <= nmi_sync;
      key_comb_prev_reg <= key_comb;
    end
  end

  for (genvar i = 0; i < EXT_NUM; i++) begin : g_ext
    logic rise;
    logic fall;
    logic edge_hit;
    logic lvl_act;
    logic ctrl_hit;

    assign rise = ext_sync[i] && !ext_prev_reg[i];
    assign fall = !ext_sync[i] && ext_prev_reg[i];
    // polarity ignored with both edges; rise or fall sets
    assign edge_hit = edge_src_reg[i] ? (rise || fall)
                                      : (ext_ctrl_reg[i].polarity ? rise : fall);
    assign lvl_act  = ext_ctrl_reg[i].polarity ? ext_sync[i] : !ext_sync[i];
    assign ext_set[i] = ext_ctrl_reg[i].lvl_sense ? lvl_act : edge_hit;
    assign ctrl_hit = reg_hit(paddr, IDX_W'(IDX_EXT_CTRL0 + i));
    assign ext_clr[i] = (wr_access && ctrl_hit && !pwdata[CTRL_FLAG_BIT])
                     || (ack_valid && (ack_src == eid_src_type'(i)));

    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        ext_ctrl_reg[i] <= CTRL_RST;
      end else if (wr_access && ctrl_hit) begin
        ext_ctrl_reg[i].prio      <= pwdata[CTRL_PRIO_LSB +: PRIO_W];
        ext_ctrl_reg[i].polarity  <= pwdata[CTRL_POL_BIT];
        ext_ctrl_reg[i].lvl_sense <= pwdata[CTRL_LVS_BIT];
      end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        ext_flag_reg[i] <= 1'b0;
      end else begin
        ext_flag_reg[i] <= ext_set[i] || (ext_flag_reg[i] && !ext_clr[i]);
      end
    end

    assign ext_irq_req[i] = ext_flag_reg[i] && (ext_ctrl_reg[i].prio != PRIO_RST);
    assign ext_prio_lvl[i*PRIO_W +: PRIO_W] = ext_ctrl_reg[i].prio;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_src_reg <= EDGE_SRC_RST;
    end else if (wr_access && reg_hit(paddr, IDX_EDGE_SRC)) begin
      edge_src_reg <= pwdata[EDGE_SRC_W-1:0];
    end
  end

  assign serial_src_sel_a = edge_src_reg[EDGE_SEL_A_BIT];
  assign serial_src_sel_b = edge_src_reg[EDGE_SEL_B_BIT];

  assign nmi_clr = ack_valid && (ack_src == EID_SRC_NMI);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_pend_reg <= 1'b0;
    end else begin
      nmi_pend_reg <= (nmi_prev_reg && !nmi_sync) || (nmi_pend_reg && !nmi_clr);
    end
  end

  assign nmi_req = nmi_pend_reg;

  // analog select cuts the input path
  assign key_port_lvl = key_sync & {KEY_NUM{!key_analog_reg}};
  assign key_comb = &(key_sync | ~key_pin_input_mode | {KEY_NUM{key_analog_reg}});
  assign key_fall = key_comb_prev_reg && !key_comb;
  assign key_clr  = (wr_access && reg_hit(paddr, IDX_KEY_CTRL) && !pwdata[CTRL_FLAG_BIT])
                 || (ack_valid && (ack_src == EID_SRC_KEY));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      key_flag_reg <= 1'b0;
    end else begin
      key_flag_reg <= key_fall || (key_flag_reg && !key_clr);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      key_prio_reg <= PRIO_RST;
    end else if (wr_access && reg_hit(paddr, IDX_KEY_CTRL)) begin
      key_prio_reg <= pwdata[CTRL_PRIO_LSB +: PRIO_W];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      key_analog_reg <= 1'b0;
    end else if (wr_access && reg_hit(paddr, IDX_KEY_ANALOG)) begin
      key_analog_reg <= pwdata[0];
    end
  end

  assign key_irq_req  = key_flag_reg && (key_prio_reg != PRIO_RST);
  assign key_prio_lvl = key_prio_reg;
  assign key_wake_req = key_flag_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      match_en_reg <= '0;
    end else if (wr_access && reg_hit(paddr, IDX_MATCH_EN)) begin
      match_en_reg <= pwdata[MATCH_NUM-1:0];
    end
  end

  for (genvar m = 0; m < MATCH_NUM; m++) begin : g_madr
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        match_addr_reg[m] <= '0;
      end else if (wr_access && reg_hit(paddr, IDX_W'(IDX_MATCH_ADR0 + m))) begin
        match_addr_reg[m] <= pwdata[FETCH_W-1:0];
      end
    end
  end

  eid_match #(
    .FETCH_W (FETCH_W)
  ) u_match (
    .match_addr (match_addr_reg),
    .match_en   (match_en_reg),
    .fetch_addr (fetch_addr),
    .insn_start (insn_start),
    .match_req  (match_req)
  );

  // Read decode
  always_comb begin
    rd_data   = RD_ZERO;
    rd_mapped = 1'b0;
    if (reg_hit(paddr, IDX_EDGE_SRC)) begin
      rd_data[EDGE_SRC_W-1:0] = edge_src_reg;
      rd_mapped = 1'b1;
    end else if (reg_hit(paddr, IDX_KEY_CTRL)) begin
      rd_data[CTRL_PRIO_LSB +: PRIO_W] = key_prio_reg;
      rd_data[CTRL_FLAG_BIT]           = key_flag_reg;
      rd_mapped = 1'b1;
    end else if (reg_hit(paddr, IDX_KEY_ANALOG)) begin
      rd_data[0] = key_analog_reg;
      rd_mapped  = 1'b1;
    end else if (reg_hit(paddr, IDX_PORT_IN)) begin
      // live level of the non-maskable pin
      rd_data[PORT_NMI_BIT]                 = nmi_sync;
      rd_data[PORT_KEY_LSB +: KEY_NUM]      = key_port_lvl;
      rd_mapped = 1'b1;
    end else if (reg_hit(paddr, IDX_MATCH_EN)) begin
      rd_data[MATCH_NUM-1:0] = match_en_reg;
      rd_mapped = 1'b1;
    end
    for (int i = 0; i < EXT_NUM; i++) begin
      if (reg_hit(paddr, IDX_W'(IDX_EXT_CTRL0 + i))) begin
        rd_data[CTRL_PRIO_LSB +: PRIO_W] = ext_ctrl_reg[i].prio;
        rd_data[CTRL_FLAG_BIT]           = ext_flag_reg[i];
        rd_data[CTRL_POL_BIT]            = ext_ctrl_reg[i].polarity;
        rd_data[CTRL_LVS_BIT]            = ext_ctrl_reg[i].lvl_sense;
        rd_mapped = 1'b1;
      end
    end
    for (int m = 0; m < MATCH_NUM; m++) begin
      if (reg_hit(paddr, IDX_W'(IDX_MATCH_ADR0 + m))) begin
        rd_data[FETCH_W-1:0] = match_addr_reg[m];
        rd_mapped = 1'b1;
      end
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg <= RD_ZERO;
      err_reg    <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= pwrite ? RD_ZERO : rd_data;
      err_reg    <= !rd_mapped;
    end
  end
endmodule // eid_top
